// ==== hdl/qrw_regs.svh ====
`ifndef QRW_REGS_SVH
`define QRW_REGS_SVH

// Instruction codes.
`define QRW_OP_QREAD     8'heb
`define QRW_OP_QWORD     8'he7
`define QRW_OP_ID1       8'h90
`define QRW_OP_ID2       8'h92
`define QRW_OP_ID4       8'h94
`define QRW_OP_WRAP      8'h77
`define QRW_OP_CRM_RST   8'hff

// Phase lengths in bits on the link.
`define QRW_CMD_BITS     6'h08
`define QRW_ADDR_BITS    6'h18
`define QRW_MODE_BITS    6'h08
`define QRW_DUMMY4_BITS  6'h10
`define QRW_DUMMY2_BITS  6'h08
`define QRW_BYTE_BITS    4'h8

// Fields and reset values.
`define QRW_CONT_CODE    2'h2
`define QRW_MODE_CONT_HI 5
`define QRW_MODE_CONT_LO 4
`define QRW_WRAP_HI      6
`define QRW_WRAP_LO      4
`define QRW_WRAP_DIS_BIT 0
`define QRW_WRAP_RST     3'h1
`define QRW_WRAP_LEN_MIN 8'h08
`define QRW_ID_SWAP_ADDR 24'h00_0001

// Timing.
`define QRW_SCLK_PERIOD_NS 80
`define QRW_SYS_PERIOD_NS  8

`endif

// ==== hdl/qrw_pkg.sv ====
`include "qrw_regs.svh"

package qrw_pkg;

    typedef enum logic [2:0] {
        PH_IDLE   = 3'b000,
        PH_CMD    = 3'b001,
        PH_ADDR   = 3'b010,
        PH_MODE   = 3'b011,
        PH_DUMMY  = 3'b100,
        PH_DATA   = 3'b101,
        PH_IGNORE = 3'b110,
        PH_END    = 3'b111
    } qrw_phase_t;

    typedef struct packed {
        logic       valid;
        logic [2:0] lanes;
        logic       has_mode;
        logic [5:0] dummy_bits;
        logic       has_data;
        logic       is_id;
        logic       is_wrap;
        logic       is_quad;
    } qrw_op_t;

    function automatic qrw_op_t qrw_decode(input logic [7:0] op);
        qrw_op_t r;
        r = '0;
        case (op)
            `QRW_OP_QREAD: r = '{1'b1, 3'd4, 1'b1, `QRW_DUMMY4_BITS, 1'b1, 1'b0, 1'b0, 1'b1};
            `QRW_OP_QWORD: r = '{1'b1, 3'd4, 1'b1, `QRW_DUMMY2_BITS, 1'b1, 1'b0, 1'b0, 1'b1};
            `QRW_OP_ID1:   r = '{1'b1, 3'd1, 1'b0, 6'h00, 1'b1, 1'b1, 1'b0, 1'b0};
            `QRW_OP_ID2:   r = '{1'b1, 3'd2, 1'b0, 6'h00, 1'b1, 1'b1, 1'b0, 1'b0};
            `QRW_OP_ID4:   r = '{1'b1, 3'd4, 1'b0, `QRW_DUMMY4_BITS, 1'b1, 1'b1, 1'b0, 1'b0};
            `QRW_OP_WRAP:  r = '{1'b1, 3'd1, 1'b1, 6'h00, 1'b0, 1'b0, 1'b1, 1'b0};
            default:       r = '0;
        endcase
        return r;
    endfunction : qrw_decode

    // Bits taken from the lines when the other end drives them, right aligned.
    function automatic logic [3:0] qrw_in_bits(input logic [2:0] lw, input logic [3:0] io);
        case (lw)
            3'd4:    return io;
            3'd2:    return {2'b00, io[1:0]};
            default: return {3'b000, io[0]};
        endcase
    endfunction : qrw_in_bits

    function automatic logic [3:0] qrw_lane_oe(input logic [2:0] lw);
        case (lw)
            3'd4:    return 4'hf;
            3'd2:    return 4'h3;
            default: return 4'h1;
        endcase
    endfunction : qrw_lane_oe

endpackage : qrw_pkg

// ==== hdl/qrw_if.sv ====
`timescale 1ns/1ps
`default_nettype none

interface qrw_if;
    logic       cs_n;
    logic       sclk;
    logic [3:0] h_io_o;
    logic [3:0] h_io_oe;
    logic [3:0] d_io_o;
    logic [3:0] d_io_oe;
    wire  [3:0] io;

    // Lines float high when nobody drives them.
    assign io = (d_io_oe & d_io_o) | (~d_io_oe & h_io_oe & h_io_o) | (~d_io_oe & ~h_io_oe);

    modport dev (input cs_n, input sclk, input io, output d_io_o, output d_io_oe);
    modport host (output cs_n, output sclk, output h_io_o, output h_io_oe, input io);
endinterface : qrw_if

`default_nettype wire

// ==== hdl/qrw_dev.sv ====
// Summary of operation
// RULE_01 - Quad read: address, mode, four dummy clocks.
// RULE_02 - Data four bits per clock, address increments.
// RULE_03 - Quad reads accepted only with quad enable.
// RULE_04 - Mode code 10 skips opcode next transfer.
// RULE_05 - Other mode codes return to opcode decoding.
// RULE_06 - Reset command clears continuous read state.
// RULE_07 - Word read: even address, two dummy clocks.
// RULE_08 - Word read honours continuous read too.
// RULE_09 - Wrap inside aligned section until select rises.
// RULE_10 - Wrap setting holds until rewritten.
// RULE_11 - Wrap set: opcode, 24 dummy, 8 bits.
// RULE_12 - Wrap disable bit, set at reset.
// RULE_13 - Length select: 8, 16, 32, 64 bytes.
// RULE_14 - ID read: zero address, maker then device.
// RULE_15 - Address one gives device ID first.
// RULE_16 - Dual ID read two bits per clock.
// RULE_17 - Quad ID read: address, four dummy clocks.
// RULE_18 - Select high ends command and output.
// RULE_19 - ID bytes alternate while clocks continue.
// RULE_20 - Other reads ignore wrap, linear addressing.
`timescale 1ns/1ps
`default_nettype none
`include "qrw_regs.svh"

module qrw_dev #(
    parameter logic [7:0] MFR_ID = 8'h5a,  // Arbitrary value.
    parameter logic [7:0] DEV_ID = 8'h3c   // Arbitrary value.
) (
    // Clock and reset.
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst,
    // Serial link.
    qrw_if.dev               link,
    // User side.
    input  wire logic        i_quad_lines_enable,
    input  wire logic [7:0]  i_mem_data,
    output logic      [23:0] o_mem_addr,
    output logic      [2:0]  o_wrap_setting,
    output logic             o_cont_read
);

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers: bit 0 select, bit 1 clock, bits 5..2 data lines.

    localparam int NSYNC = 6;

    logic [NSYNC-1:0] s1_ff;
    logic [NSYNC-1:0] s2_ff;
    logic [NSYNC-1:0] s3_ff;
    logic [NSYNC-1:0] st_ff;
    wire  [NSYNC-1:0] raw_in;
    wire  [NSYNC-1:0] agree;

    assign raw_in = {link.io, link.sclk, link.cs_n};
    assign agree  = ~(s2_ff ^ s3_ff);

    always_ff @(posedge i_sys_clk) begin
        s1_ff <= raw_in;
        s2_ff <= s1_ff;
        s3_ff <= s2_ff;
    end

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_stable
            always_ff @(posedge i_sys_clk) begin
                if (i_rst) begin
                    // Idle levels: select and data lines high, link clock low.
                    st_ff[gi] <= (gi != 1);
                end else if (agree[gi]) begin
                    st_ff[gi] <= s3_ff[gi];
                end
            end
        end
    endgenerate

    wire       sclk_rise = agree[1] & s3_ff[1] & ~st_ff[1];
    wire       sclk_fall = agree[1] & ~s3_ff[1] & st_ff[1];
    wire       cs_fall   = agree[0] & ~s3_ff[0] & st_ff[0];
    wire       cs_rise   = agree[0] & s3_ff[0] & ~st_ff[0];
    wire [3:0] io_in     = st_ff[5:2];

    ////////////////////////////////////////////////////////////////////////////
    // Command state.

    qrw_pkg::qrw_phase_t ph_ff;
    qrw_pkg::qrw_op_t    op_ff;
    qrw_pkg::qrw_op_t    cont_op_ff;
    logic [5:0]          cnt_ff;
    logic [2:0]          lw_ff;
    logic [23:0]         sh_ff;
    logic [23:0]         addr_ff;
    logic                cont_ff;
    logic [2:0]          wrap_ff;
    logic [7:0]          osh_ff;
    logic [3:0]          obit_ff;
    logic                id_sel_ff;
    logic [3:0]          io_o_ff;
    logic [3:0]          io_oe_ff;

    wire [5:0]  nxt_cnt = cnt_ff + {3'b000, lw_ff};
    wire [23:0] nxt_sh  = (sh_ff << lw_ff) | {20'h0_0000, qrw_pkg::qrw_in_bits(lw_ff, io_in)};
    wire [7:0]  nxt_op  = nxt_sh[7:0];

    qrw_pkg::qrw_op_t dec_op;
    assign dec_op = qrw_pkg::qrw_decode(nxt_op);

    logic [5:0] ph_len;
    always_comb begin
        case (ph_ff)
            qrw_pkg::PH_CMD:   ph_len = `QRW_CMD_BITS;
            qrw_pkg::PH_ADDR:  ph_len = `QRW_ADDR_BITS;
            qrw_pkg::PH_MODE:  ph_len = `QRW_MODE_BITS;
            qrw_pkg::PH_DUMMY: ph_len = op_ff.dummy_bits;
            default:           ph_len = 6'h3f;
        endcase
    end
    wire ph_done = (nxt_cnt == ph_len);

    // Quad reads are refused unless the quad enable bit is set.
    wire op_ok  = dec_op.valid & (~dec_op.is_quad | i_quad_lines_enable); // RULE_03
    wire cont_go = cont_ff & i_quad_lines_enable; // RULE_03

    // Phase after the address: mode byte, then dummy clocks, then data.
    qrw_pkg::qrw_phase_t after_addr;
    assign after_addr = op_ff.has_mode ? qrw_pkg::PH_MODE : // RULE_01
                        (op_ff.dummy_bits != 6'h00) ? qrw_pkg::PH_DUMMY : // RULE_17
                        op_ff.has_data ? qrw_pkg::PH_DATA : qrw_pkg::PH_IGNORE; // RULE_14 RULE_16

    ////////////////////////////////////////////////////////////////////////////
    // Read data path.

    // Wrap applies to the two quad reads only; all others run linearly.
    wire        wrap_on  = op_ff.is_quad & ~wrap_ff[`QRW_WRAP_DIS_BIT]; // RULE_12 RULE_20
    wire [7:0]  wmask    = (`QRW_WRAP_LEN_MIN << wrap_ff[2:1]) - 8'h01; // RULE_13
    wire [23:0] addr_inc = addr_ff + 24'h00_0001; // RULE_02
    wire [23:0] addr_wrp = {addr_ff[23:8], (addr_ff[7:0] & ~wmask) | (addr_inc[7:0] & wmask)};
    wire [23:0] addr_nxt = wrap_on ? addr_wrp : addr_inc; // RULE_09 RULE_10

    wire [7:0]  id_byte  = id_sel_ff ? DEV_ID : MFR_ID;
    wire [7:0]  src_byte = op_ff.is_id ? id_byte : i_mem_data;
    wire [7:0]  cur_byte = (obit_ff == 4'h0) ? src_byte : osh_ff;
    wire [3:0]  nxt_obit = obit_ff + {1'b0, lw_ff};
    wire        byte_end = (nxt_obit == `QRW_BYTE_BITS);

    // A single-line read answers on line 1, the usual serial output.
    logic [3:0] drv_bits;
    logic [3:0] drv_oe;
    always_comb begin
        case (lw_ff)
            3'd4: begin
                drv_bits = cur_byte[7:4];
                drv_oe   = 4'hf;
            end
            3'd2: begin
                drv_bits = {2'b00, cur_byte[7:6]};
                drv_oe   = 4'h3;
            end
            default: begin
                drv_bits = {2'b00, cur_byte[7], 1'b0};
                drv_oe   = 4'h2;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer.

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            ph_ff      <= qrw_pkg::PH_IDLE;
            op_ff      <= '0;
            cont_op_ff <= '0;
            cnt_ff     <= 6'h00;
            lw_ff      <= 3'd1;
            sh_ff      <= 24'h00_0000;
            addr_ff    <= 24'h00_0000;
            cont_ff    <= 1'b0;
            wrap_ff    <= `QRW_WRAP_RST; // RULE_12
            osh_ff     <= 8'h00;
            obit_ff    <= 4'h0;
            id_sel_ff  <= 1'b0;
            io_o_ff    <= 4'h0;
            io_oe_ff   <= 4'h0;
        end else if (cs_rise) begin
            ph_ff    <= qrw_pkg::PH_IDLE; // RULE_18
            io_oe_ff <= 4'h0; // RULE_18
        end else if (cs_fall) begin
            cnt_ff  <= 6'h00;
            sh_ff   <= 24'h00_0000;
            obit_ff <= 4'h0;
            if (cont_go) begin
                ph_ff <= qrw_pkg::PH_ADDR; // RULE_04 RULE_08
                op_ff <= cont_op_ff;
                lw_ff <= 3'd4;
            end else begin
                ph_ff <= qrw_pkg::PH_CMD; // RULE_05
                lw_ff <= 3'd1;
            end
        end else if (sclk_rise) begin
            sh_ff  <= nxt_sh;
            cnt_ff <= ph_done ? 6'h00 : nxt_cnt;
            if (ph_done) begin
                case (ph_ff)
                    qrw_pkg::PH_CMD: begin
                        if (nxt_op == `QRW_OP_CRM_RST) begin
                            cont_ff <= 1'b0; // RULE_06
                        end
                        op_ff <= dec_op;
                        lw_ff <= dec_op.lanes;
                        ph_ff <= op_ok ? qrw_pkg::PH_ADDR : qrw_pkg::PH_IGNORE;
                    end
                    qrw_pkg::PH_ADDR: begin
                        addr_ff   <= nxt_sh;
                        id_sel_ff <= (nxt_sh == `QRW_ID_SWAP_ADDR); // RULE_15
                        ph_ff     <= after_addr;
                    end
                    qrw_pkg::PH_MODE: begin
                        if (op_ff.is_wrap) begin
                            wrap_ff <= nxt_sh[`QRW_WRAP_HI:`QRW_WRAP_LO]; // RULE_11 RULE_10
                            ph_ff   <= qrw_pkg::PH_IGNORE;
                        end else begin
                            cont_ff <= (nxt_sh[`QRW_MODE_CONT_HI:`QRW_MODE_CONT_LO]
                                        == `QRW_CONT_CODE); // RULE_04 RULE_05 RULE_08
                            cont_op_ff <= op_ff;
                            ph_ff      <= qrw_pkg::PH_DUMMY; // RULE_01 RULE_07
                        end
                    end
                    qrw_pkg::PH_DUMMY: begin
                        ph_ff   <= qrw_pkg::PH_DATA;
                        obit_ff <= 4'h0;
                    end
                    default: begin
                        ph_ff <= ph_ff;
                    end
                endcase
            end
        end else if (sclk_fall && ph_ff == qrw_pkg::PH_DATA) begin
            io_o_ff  <= drv_bits; // RULE_02 RULE_16 RULE_17
            io_oe_ff <= drv_oe;
            osh_ff   <= cur_byte << lw_ff;
            obit_ff  <= byte_end ? 4'h0 : nxt_obit;
            if (byte_end) begin
                if (op_ff.is_id) begin
                    id_sel_ff <= ~id_sel_ff; // RULE_19 RULE_14
                end else begin
                    addr_ff <= addr_nxt; // RULE_02 RULE_09
                end
            end
        end
    end

    assign link.d_io_o    = io_o_ff;
    assign link.d_io_oe   = io_oe_ff;
    assign o_mem_addr     = addr_ff;
    assign o_wrap_setting = wrap_ff;
    assign o_cont_read    = cont_ff;

endmodule : qrw_dev

`default_nettype wire

// ==== hdl/qrw_host.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "qrw_regs.svh"

module qrw_host #(
    parameter int HALF = `QRW_SCLK_PERIOD_NS / (2 * `QRW_SYS_PERIOD_NS)
) (
    // Clock and reset.
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst,
    // Serial link.
    qrw_if.host              link,
    // Command port.
    input  wire logic        i_start,
    input  wire logic [7:0]  i_opcode,
    input  wire logic [23:0] i_addr,
    input  wire logic [7:0]  i_mode,
    input  wire logic        i_skip_opcode,
    input  wire logic [7:0]  i_nbytes,
    // Answer.
    output logic             o_busy,
    output logic      [7:0]  o_rd_data,
    output logic             o_rd_valid
);

    // The device answers about four cycles after a falling edge and the host
    // needs four more to settle it, so a shorter half period reads stale data.
    if (HALF < 5) begin : g_half_check
        $error("qrw_host: HALF must be at least 5");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Data line synchronisers.

    logic [3:0] s1_ff;
    logic [3:0] s2_ff;
    logic [3:0] s3_ff;
    logic [3:0] st_ff;

    always_ff @(posedge i_sys_clk) begin
        s1_ff <= link.io;
        s2_ff <= s1_ff;
        s3_ff <= s2_ff;
    end

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_stable
            always_ff @(posedge i_sys_clk) begin
                if (i_rst) begin
                    st_ff[gi] <= 1'b1;
                end else if (s2_ff[gi] == s3_ff[gi]) begin
                    st_ff[gi] <= s3_ff[gi];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Transfer sequencer.

    qrw_pkg::qrw_phase_t ph_ff;
    qrw_pkg::qrw_op_t    op_ff;
    logic [15:0]         div_ff;
    logic                sclk_ff;
    logic                cs_n_ff;
    logic [5:0]          cnt_ff;
    logic [2:0]          lw_ff;
    logic [23:0]         sh_ff;
    logic [23:0]         addr_ff;
    logic [7:0]          mode_ff;
    logic [7:0]          nb_ff;
    logic [7:0]          rsh_ff;
    logic [3:0]          rbit_ff;
    logic [7:0]          rd_data_ff;
    logic                rd_valid_ff;
    logic [3:0]          io_o_ff;
    logic [3:0]          io_oe_ff;

    qrw_pkg::qrw_op_t st_op;
    assign st_op = qrw_pkg::qrw_decode(i_opcode);

    wire        tick     = (div_ff == 16'(HALF - 1));
    wire        fall     = tick & sclk_ff;
    wire [5:0]  nxt_cnt  = cnt_ff + {3'b000, lw_ff};
    wire [23:0] sh_shift = sh_ff << lw_ff;
    wire [3:0]  rx_bits  = (lw_ff == 3'd1) ? {3'b000, st_ff[1]} : qrw_pkg::qrw_in_bits(lw_ff, st_ff);
    wire [7:0]  nxt_rsh  = (rsh_ff << lw_ff) | {4'h0, rx_bits};
    wire [3:0]  nxt_rbit = rbit_ff + {1'b0, lw_ff};
    wire        rx_byte  = (nxt_rbit == `QRW_BYTE_BITS);

    logic [5:0] ph_len;
    always_comb begin
        case (ph_ff)
            qrw_pkg::PH_CMD:   ph_len = `QRW_CMD_BITS;
            qrw_pkg::PH_ADDR:  ph_len = `QRW_ADDR_BITS;
            qrw_pkg::PH_MODE:  ph_len = `QRW_MODE_BITS;
            qrw_pkg::PH_DUMMY: ph_len = op_ff.dummy_bits;
            default:           ph_len = 6'h3f;
        endcase
    end
    wire ph_done = (nxt_cnt == ph_len);

    // Next phase once the current one has been clocked out.
    qrw_pkg::qrw_phase_t ph_next;
    always_comb begin
        case (ph_ff)
            qrw_pkg::PH_CMD:   ph_next = op_ff.valid ? qrw_pkg::PH_ADDR : qrw_pkg::PH_END;
            qrw_pkg::PH_ADDR:  ph_next = op_ff.has_mode ? qrw_pkg::PH_MODE :
                                         (op_ff.dummy_bits != 6'h00) ? qrw_pkg::PH_DUMMY :
                                         qrw_pkg::PH_DATA;
            qrw_pkg::PH_MODE:  ph_next = op_ff.is_wrap ? qrw_pkg::PH_END : qrw_pkg::PH_DUMMY;
            default:           ph_next = qrw_pkg::PH_DATA;
        endcase
    end
    wire        nxt_is_data = (ph_next == qrw_pkg::PH_DATA);
    wire        data_none   = nxt_is_data & (nb_ff == 8'h00);
    wire [23:0] nxt_load    = (ph_next == qrw_pkg::PH_ADDR) ? addr_ff : {mode_ff, 16'h0000};
    wire        nxt_drives  = (ph_next == qrw_pkg::PH_ADDR) | (ph_next == qrw_pkg::PH_MODE);

    function automatic logic [3:0] top_bits(input logic [23:0] v, input logic [2:0] lw);
        case (lw)
            3'd4:    return v[23:20];
            3'd2:    return {2'b00, v[23:22]};
            default: return {3'b000, v[23]};
        endcase
    endfunction : top_bits

    always_ff @(posedge i_sys_clk) begin
        rd_valid_ff <= 1'b0;
        if (i_rst) begin
            ph_ff      <= qrw_pkg::PH_IDLE;
            op_ff      <= '0;
            div_ff     <= 16'h0000;
            sclk_ff    <= 1'b0;
            cs_n_ff    <= 1'b1;
            cnt_ff     <= 6'h00;
            lw_ff      <= 3'd1;
            sh_ff      <= 24'h00_0000;
            addr_ff    <= 24'h00_0000;
            mode_ff    <= 8'h00;
            nb_ff      <= 8'h00;
            rsh_ff     <= 8'h00;
            rbit_ff    <= 4'h0;
            rd_data_ff <= 8'h00;
            io_o_ff    <= 4'h0;
            io_oe_ff   <= 4'h0;
        end else if (ph_ff == qrw_pkg::PH_IDLE) begin
            if (i_start) begin
                op_ff   <= st_op;
                addr_ff <= i_addr;
                mode_ff <= i_mode;
                nb_ff   <= i_nbytes;
                cs_n_ff <= 1'b0;
                div_ff  <= 16'h0000;
                cnt_ff  <= 6'h00;
                rbit_ff <= 4'h0;
                if (i_skip_opcode) begin
                    ph_ff    <= qrw_pkg::PH_ADDR;
                    lw_ff    <= st_op.lanes;
                    sh_ff    <= i_addr;
                    io_o_ff  <= top_bits(i_addr, st_op.lanes);
                    io_oe_ff <= qrw_pkg::qrw_lane_oe(st_op.lanes);
                end else begin
                    ph_ff    <= qrw_pkg::PH_CMD;
                    lw_ff    <= 3'd1;
                    sh_ff    <= {i_opcode, 16'h0000};
                    io_o_ff  <= {3'b000, i_opcode[7]};
                    io_oe_ff <= 4'h1;
                end
            end
        end else if (ph_ff == qrw_pkg::PH_END) begin
            // Select stays high for one half period before the next start.
            div_ff <= tick ? 16'h0000 : div_ff + 16'h0001;
            if (tick) begin
                ph_ff <= qrw_pkg::PH_IDLE;
            end
        end else begin
            div_ff <= tick ? 16'h0000 : div_ff + 16'h0001;
            if (tick) begin
                sclk_ff <= ~sclk_ff;
            end
            if (fall && ph_ff == qrw_pkg::PH_DATA) begin
                rsh_ff  <= nxt_rsh;
                rbit_ff <= rx_byte ? 4'h0 : nxt_rbit;
                if (rx_byte) begin
                    rd_data_ff  <= nxt_rsh;
                    rd_valid_ff <= 1'b1;
                    nb_ff       <= nb_ff - 8'h01;
                    if (nb_ff == 8'h01) begin
                        ph_ff    <= qrw_pkg::PH_END; // RULE_18
                        cs_n_ff  <= 1'b1;
                    end
                end
            end else if (fall) begin
                cnt_ff <= ph_done ? 6'h00 : nxt_cnt;
                if (!ph_done) begin
                    sh_ff   <= sh_shift;
                    io_o_ff <= top_bits(sh_shift, lw_ff);
                end else if (ph_next == qrw_pkg::PH_END || data_none) begin
                    ph_ff    <= qrw_pkg::PH_END; // RULE_11 RULE_18
                    cs_n_ff  <= 1'b1;
                    io_oe_ff <= 4'h0;
                end else begin
                    ph_ff    <= ph_next;
                    lw_ff    <= (ph_ff == qrw_pkg::PH_CMD) ? op_ff.lanes : lw_ff;
                    sh_ff    <= nxt_load;
                    io_o_ff  <= top_bits(nxt_load, (ph_ff == qrw_pkg::PH_CMD) ? op_ff.lanes : lw_ff);
                    io_oe_ff <= nxt_drives ? qrw_pkg::qrw_lane_oe(
                                    (ph_ff == qrw_pkg::PH_CMD) ? op_ff.lanes : lw_ff) : 4'h0;
                end
            end
        end
    end

    assign link.cs_n    = cs_n_ff;
    assign link.sclk    = sclk_ff;
    assign link.h_io_o  = io_o_ff;
    assign link.h_io_oe = io_oe_ff;
    assign o_busy       = (ph_ff != qrw_pkg::PH_IDLE);
    assign o_rd_data    = rd_data_ff;
    assign o_rd_valid   = rd_valid_ff;

endmodule : qrw_host

`default_nettype wire

// ==== tb/qrw_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module qrw_chk (
    // Clock and reset.
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst,
    // Link.
    input  wire logic       cs_n,
    input  wire logic       sclk,
    input  wire logic [3:0] h_io_oe,
    input  wire logic [3:0] d_io_oe,
    input  wire logic [3:0] io
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    sequence sel_start;
        $fell(cs_n);
    endsequence
    sequence clk_high;
        sclk[*5] ##1 !sclk;
    endsequence
    one_driver_a: assert property (~|(d_io_oe & h_io_oe))
        else $error("Both ends drive the lines.");
    quiet_cmd_a: assert property (sel_start |-> (d_io_oe == 4'h0)[*8])
        else $error("Device drives at frame start.");
    sclk_width_a: assert property ($rose(sclk) |-> clk_high)
        else $error("Link clock high time wrong.");
    idle_clk_a: assert property (sel_start |-> !sclk)
        else $error("Link clock high at select.");
    release_a: assert property ($rose(cs_n) |-> ##8 (d_io_oe == 4'h0))
        else $error("Device still drives after select.");
    cs_idle_a: assert property (cs_n && $past(cs_n) |-> !sclk)
        else $error("Link clock runs while idle.");
    lanes_a: assert property (d_io_oe inside {4'h0, 4'h2, 4'h3, 4'hf})
        else $error("Illegal device lane set.");
    // Data may only move while the clock is low, so the host sees it settled.
    hold_high_a: assert property (|d_io_oe && $past(|d_io_oe) && sclk && $past(sclk) |-> $stable(io))
        else $error("Device data moved while clock high.");
endmodule : qrw_chk
`default_nettype wire

// ==== tb/qrw_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module qrw_tb;
    logic        clk = 0, rst = 1, start = 0, skip = 0, qe = 1, busy, vld, cont;
    logic [7:0]  op = 0, md = 0, nb = 0, mem = 0, rd;
    logic [23:0] ad = 0, maddr;
    logic [2:0]  w = 3'h1, ws;
    logic [31:0] seed = 32'hce47_55db;
    int          err_count = 0, n_compared = 0;
    qrw_if lnk ();
    always #4 clk = ~clk;
    qrw_host u_qrw_host (.i_sys_clk(clk), .i_rst(rst), .link(lnk), .i_start(start), .i_opcode(op),
        .i_addr(ad), .i_mode(md), .i_skip_opcode(skip), .i_nbytes(nb), .o_busy(busy),
        .o_rd_data(rd), .o_rd_valid(vld));
    qrw_dev u_qrw_dev (.i_sys_clk(clk), .i_rst(rst), .link(lnk), .i_quad_lines_enable(qe),
        .i_mem_data(mem), .o_mem_addr(maddr), .o_wrap_setting(ws), .o_cont_read(cont));
    qrw_chk u_qrw_chk (.i_sys_clk(clk), .i_rst(rst), .cs_n(lnk.cs_n), .sclk(lnk.sclk),
        .h_io_oe(lnk.h_io_oe), .d_io_oe(lnk.d_io_oe), .io(lnk.io));
    always @(negedge clk) mem <= maddr[7:0] ^ maddr[15:8] ^ 8'h3c;
    ////////////////////////////////////////////////////////////////
    function automatic logic [7:0] exb(input logic [7:0] o, input logic [23:0] a, input int k);
        logic [23:0] l;
        l = 24'h8 << w[2:1];
        if (o inside {8'h90, 8'h92, 8'h94}) return ((k + a[0]) % 2) ? 8'h3c : 8'h5a;
        if (!w[0]) a = a - a % l + (a % l + k) % l;
        else a = a + k;
        return a[7:0] ^ a[15:8] ^ 8'h3c;
    endfunction : exb
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task end_sim;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_sim
    // A refused read leaves the lines to the pull-ups, so every byte reads as all ones.
    task run(input logic [7:0] o, input logic [23:0] a, input logic [7:0] m, input logic sk,
        input logic [7:0] n);
        int k, t;
        k = 0;
        t = 0;
        @(negedge clk);
        {start, op, ad, md, skip, nb} = {1'b1, o, a, m, sk, n};
        @(negedge clk);
        start = 0;
        while (busy !== 1'b0 && t < 4000) begin
            @(posedge clk);
            #1;
            t++;
            if (vld === 1'b1) begin
                chk("rd_data", rd, qe ? exb(o, a, k) : 8'hff);
                k++;
            end
        end
        chk("byte_count", k, n);
        chk("busy_end", busy, 1'b0);
    endtask : run
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge clk);
        @(negedge clk);
        rst = 0;
        repeat (4) @(negedge clk);
        chk("wrap_reset", ws, 3'h1);
        for (int l = 0; l < 4; l++) begin
            w = {l[1:0], 1'b0};
            run(8'h77, 0, {1'b0, w, 4'h0}, 0, 0);
            chk("wrap_set", ws, w);
            seed = xs(seed);
            run(8'heb, {seed[23:6], 6'h3f}, 0, 0, 20);
        end
        for (int i = 0; i < 2; i++) begin
            seed = xs(seed);
            run(i ? 8'he7 : 8'heb, {seed[23:1], 1'b0}, 8'h20, 0, 5);
            chk("cont_on", cont, 1);
            run(i ? 8'he7 : 8'heb, {seed[22:0], 1'b0}, 8'hc5, 1, 9);
            chk("cont_off", cont, 0);
        end
        for (int i = 0; i < 6; i++) run(8'h90 + 8'(i / 2 * 2), 24'(i % 2), 0, 0, 3);
        w = 3'h7;
        run(8'h77, 0, 8'h70, 0, 0);
        chk("wrap_off", ws, w);
        run(8'heb, 24'h00_00fe, 0, 0, 4);
        qe = 0;
        run(8'heb, seed[23:0], 8'h20, 0, 2);
        chk("cont_refused", cont, 0);
        qe = 1;
        run(8'heb, 0, 8'h20, 0, 1);
        run(8'hff, 0, 0, 0, 0);
        chk("cont_reset", cont, 0);
        end_sim;
    end
    initial begin
        repeat (100000) @(posedge clk);
        err_count++;
        end_sim;
    end
endmodule : qrw_tb
`default_nettype wire
